// >>> pkg/fsr_consts.vh
// Command codes, register addresses and field positions for the flag bank
`ifndef FSR_CONSTS_VH
`define FSR_CONSTS_VH
`define FSR_CMD_RD_SR2 8'h07
`define FSR_CMD_RD_ANY 8'h65
`define FSR_CMD_WR_ANY 8'h71
`define FSR_CMD_WR_REGS 8'h01
`define FSR_CMD_WR_EN 8'h06
`define FSR_CMD_CLR 8'h30
`define FSR_ADDR_SR2 24'h000001
`define FSR_ADDR_CONFIG_ONE_PERSISTENT 24'h000002
`define FSR_SR2_RESET 8'h00
`define FSR_CONFIG_ONE_PERSISTENT_RESET 8'h00
`define FSR_BIT_EERR 6
`define FSR_BIT_PERR 5
`define FSR_BIT_ESUS 1
`define FSR_BIT_PSUS 0
`define FSR_BIT_SUSD 7
`define FSR_BIT_CMPD 6
`define FSR_LB_HI 5
`define FSR_LB_LO 2
`define FSR_BIT_QUADD 1
`define FSR_BIT_SRPD 0
`define FSR_PROT_OTP_OPEN 3'h7
`define FSR_ADDR_BYTES 3'h3
`define FSR_WRR_BYTES 3'h2
`define FSR_WRANY_BYTES 3'h4
`endif

// >>> hdl/fsr_sync.v
// Two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module fsr_sync #(
   parameter WIDTH = 3
) (
   input wire clk,
   input wire nrst,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : gBit
         reg stage1_q;
         reg stage2_q;
         // First stage feeds only the second
         always @(posedge clk) begin
            if (!nrst) begin
               stage1_q <= 1'b1;
               stage2_q <= 1'b1;
            end else begin
               stage1_q <= asyncIn[i];
               stage2_q <= stage1_q;
            end
         end
         assign syncOut[i] = stage2_q;
      end
   endgenerate
endmodule
`default_nettype wire

// >>> hdl/fsr_flag_bank.v
// Serial flash error/suspend status and persistent config register bank
`timescale 1ns/1ps
`default_nettype none
`include "fsr_consts.vh"
module fsr_flag_bank (
   input wire clk,
   input wire nrst,
   input wire csN,
   input wire sclk,
   input wire mosi,
   output reg miso_q,
   output reg misoOe_q,
   input wire opReq,
   input wire opIsErase,
   input wire opIsChip,
   input wire opSecurity,
   input wire [1:0] opRegion,
   input wire opSectorProt,
   input wire opDone,
   input wire opFail,
   input wire chipProtHit,
   input wire eraseHalted,
   input wire programHalted,
   input wire [2:0] protectionModeField,
   input wire cfgReload,
   output reg opAccept_q,
   output reg busyFlag_q,
   output reg haltedOpIndicator_q,
   output reg invertMapBit_q,
   output reg fourLaneEn_q,
   output reg regLockLive_q,
   output reg [3:0] regionLock_q
);
   localparam [2:0] S_CMD = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_DATA = 3'h2;
   localparam [2:0] S_READ = 3'h3;
   localparam [2:0] S_SKIP = 3'h4;

   wire csS;
   wire sclkS;
   wire mosiS;
   reg sclkPrev_q;
   reg [2:0] state_q;
   reg [2:0] bitCnt_q;
   reg [2:0] byteCnt_q;
   reg [7:0] inShift_q;
   reg [7:0] outShift_q;
   reg [7:0] cmd_q;
   reg [23:0] addr_q;
   reg [7:0] wrData_q;
   reg wel_q;
   reg eraseErr_q;
   reg progErr_q;
   reg inOp_q;
   reg opKindErase_q;
   reg [7:0] cfgNv_q;
   reg csPrev_q;
   reg [7:0] rdByte;
   reg [7:0] cfgNv_d;
   wire sclkRise;
   wire sclkFall;
   wire csRise;
   wire [7:0] nextIn;
   wire byteEnd;
   wire clearPulse;
   wire commitAny;
   wire commitRegs;
   wire writeOk;
   wire regionLocked;
   wire opBlocked;
   wire eraseFailEvt;
   wire progFailEvt;
   wire [7:0] statusView;
   wire [7:0] sr2Reset;
   wire [23:0] rdAddr;

   fsr_sync #(.WIDTH(3)) uSync (
      .clk(clk),
      .nrst(nrst),
      .asyncIn({csN, sclk, mosi}),
      .syncOut({csS, sclkS, mosiS})
   );

   // Edge detection on the synchronised link clock
   assign sclkRise = sclkS & ~sclkPrev_q & ~csS;
   assign sclkFall = ~sclkS & sclkPrev_q & ~csS;
   assign csRise = csS & ~csPrev_q;
   assign nextIn = {inShift_q[6:0], mosiS};
   assign byteEnd = sclkRise & (bitCnt_q == 3'h7);

   always @(posedge clk) begin
      if (!nrst) begin
         sclkPrev_q <= 1'b0;
         csPrev_q <= 1'b1;
      end else begin
         sclkPrev_q <= sclkS;
         csPrev_q <= csS;
      end
   end

   // Status view: reserved bits forced low, halt bits from live state
   assign statusView = {1'b0, eraseErr_q, progErr_q, 3'h0,
                        eraseHalted, programHalted};
   assign sr2Reset = `FSR_SR2_RESET;

   // Address byte still arriving in the address phase, held afterwards
   assign rdAddr = (state_q == S_ADDR) ? {addr_q[15:0], nextIn} : addr_q;

   // Read mux for register reads, unmapped addresses return zero
   always @* begin
      rdByte = 8'h00;
      if (cmd_q == `FSR_CMD_RD_SR2) begin
         rdByte = statusView;
      end else if (rdAddr == `FSR_ADDR_SR2) begin
         rdByte = statusView;
      end else if (rdAddr == `FSR_ADDR_CONFIG_ONE_PERSISTENT) begin
         rdByte = cfgNv_q;
      end
   end

   // Serial command engine: mode 0, MSB first, data out on falling edge
   always @(posedge clk) begin
      if (!nrst) begin
         state_q <= S_CMD;
         bitCnt_q <= 3'h0;
         byteCnt_q <= 3'h0;
         inShift_q <= 8'h00;
         outShift_q <= 8'h00;
         cmd_q <= 8'h00;
         addr_q <= 24'h000000;
         wrData_q <= 8'h00;
         miso_q <= 1'b0;
         misoOe_q <= 1'b0;
      end else if (csS) begin
         // Frame over: back to command phase, release the data line
         state_q <= S_CMD;
         bitCnt_q <= 3'h0;
         byteCnt_q <= 3'h0;
         misoOe_q <= 1'b0;
      end else begin
         if (sclkRise) begin
            inShift_q <= nextIn;
            bitCnt_q <= bitCnt_q + 3'h1;
         end
         if (sclkFall && state_q == S_READ) begin
            miso_q <= outShift_q[7];
            misoOe_q <= 1'b1;
            outShift_q <= {outShift_q[6:0], 1'b0};
         end
         if (byteEnd) begin
            case (state_q)
               S_CMD: begin
                  cmd_q <= nextIn;
                  byteCnt_q <= 3'h0;
                  if (nextIn == `FSR_CMD_RD_SR2) begin
                     state_q <= S_READ;
                     outShift_q <= statusView;
                  end else if (nextIn == `FSR_CMD_RD_ANY ||
                               nextIn == `FSR_CMD_WR_ANY) begin
                     state_q <= S_ADDR;
                  end else if (nextIn == `FSR_CMD_WR_REGS) begin
                     state_q <= S_DATA;
                  end else begin
                     state_q <= S_SKIP;
                  end
               end
               S_ADDR: begin
                  addr_q <= {addr_q[15:0], nextIn};
                  byteCnt_q <= byteCnt_q + 3'h1;
                  if (byteCnt_q == `FSR_ADDR_BYTES - 3'h1) begin
                     if (cmd_q == `FSR_CMD_RD_ANY) begin
                        state_q <= S_READ;
                        outShift_q <= rdByte;
                     end else begin
                        state_q <= S_DATA;
                     end
                  end
               end
               S_DATA: begin
                  wrData_q <= nextIn;
                  if (byteCnt_q != 3'h7) begin
                     byteCnt_q <= byteCnt_q + 3'h1;
                  end
               end
               S_READ: begin
                  // Repeated reads stream the same register
                  if (cmd_q == `FSR_CMD_RD_SR2) begin
                     outShift_q <= statusView;
                  end else begin
                     outShift_q <= rdByte;
                  end
               end
               default: begin
                  state_q <= S_SKIP;
               end
            endcase
         end
      end
   end

   // Commit points at chip-select release, only on whole-byte frames
   assign writeOk = wel_q & ~regLockLive_q & ~busyFlag_q;
   assign commitRegs = csRise & (cmd_q == `FSR_CMD_WR_REGS) &
                       (state_q == S_DATA) & (bitCnt_q == 3'h0) &
                       (byteCnt_q == `FSR_WRR_BYTES) & writeOk;
   assign commitAny = csRise & (cmd_q == `FSR_CMD_WR_ANY) &
                      (state_q == S_DATA) & (bitCnt_q == 3'h0) &
                      (byteCnt_q == `FSR_WRANY_BYTES) &
                      (addr_q == `FSR_ADDR_CONFIG_ONE_PERSISTENT) & writeOk;
   assign clearPulse = byteEnd & (state_q == S_CMD) &
                       (nextIn == `FSR_CMD_CLR);

   // Persistent config update: fixed, writable and one-time fields
   always @* begin
      cfgNv_d = cfgNv_q;
      if (commitRegs || commitAny) begin
         cfgNv_d[`FSR_BIT_SUSD] = 1'b0;
         cfgNv_d[`FSR_BIT_CMPD] = wrData_q[`FSR_BIT_CMPD];
         cfgNv_d[`FSR_LB_HI:`FSR_LB_LO] = cfgNv_q[`FSR_LB_HI:`FSR_LB_LO] |
            wrData_q[`FSR_LB_HI:`FSR_LB_LO];
         cfgNv_d[`FSR_BIT_QUADD] = wrData_q[`FSR_BIT_QUADD];
         if (protectionModeField == `FSR_PROT_OTP_OPEN) begin
            cfgNv_d[`FSR_BIT_SRPD] = cfgNv_q[`FSR_BIT_SRPD] |
                                     wrData_q[`FSR_BIT_SRPD];
         end
      end
   end

   // Operation screening against region locks and sector protection
   assign regionLocked = opSecurity & regionLock_q[opRegion];
   assign opBlocked = regionLocked | (opSectorProt & ~opIsChip);
   assign eraseFailEvt = (opReq & ~busyFlag_q & opIsErase & opBlocked) |
                         (inOp_q & opKindErase_q & opDone & opFail) |
                         (inOp_q & opKindErase_q & chipProtHit);
   assign progFailEvt = (opReq & ~busyFlag_q & ~opIsErase & opBlocked) |
                        (inOp_q & ~opKindErase_q & opDone & opFail);

   // Register state; set beats clear on the failure flags
   always @(posedge clk) begin
      if (!nrst) begin
         cfgNv_q <= `FSR_CONFIG_ONE_PERSISTENT_RESET;
         eraseErr_q <= sr2Reset[`FSR_BIT_EERR];
         progErr_q <= sr2Reset[`FSR_BIT_PERR];
         wel_q <= 1'b0;
         inOp_q <= 1'b0;
         opKindErase_q <= 1'b0;
         opAccept_q <= 1'b0;
         busyFlag_q <= 1'b0;
         haltedOpIndicator_q <= 1'b0;
         invertMapBit_q <= 1'b0;
         fourLaneEn_q <= 1'b0;
         regLockLive_q <= 1'b0;
         regionLock_q <= 4'h0;
      end else begin
         cfgNv_q <= cfgNv_d;
         // Flags untouched by register writes, only set or cleared
         if (eraseFailEvt) begin
            eraseErr_q <= 1'b1;
         end else if (clearPulse) begin
            eraseErr_q <= 1'b0;
         end
         if (progFailEvt) begin
            progErr_q <= 1'b1;
         end else if (clearPulse) begin
            progErr_q <= 1'b0;
         end
         if (byteEnd && state_q == S_CMD && nextIn == `FSR_CMD_WR_EN) begin
            wel_q <= 1'b1;
         end else if (commitRegs || commitAny || clearPulse) begin
            wel_q <= 1'b0;
         end
         // Accept only when idle and free of failure flags
         opAccept_q <= opReq & ~busyFlag_q & ~opBlocked;
         if (opReq && !busyFlag_q && !opBlocked) begin
            inOp_q <= 1'b1;
            opKindErase_q <= opIsErase;
         end else if (opDone) begin
            inOp_q <= 1'b0;
         end
         busyFlag_q <= inOp_q | eraseErr_q | progErr_q |
                       eraseFailEvt | progFailEvt;
         haltedOpIndicator_q <= eraseHalted | programHalted;
         regionLock_q <= cfgNv_q[`FSR_LB_HI:`FSR_LB_LO];
         // Live copies take their defaults on reload
         if (cfgReload) begin
            invertMapBit_q <= cfgNv_q[`FSR_BIT_CMPD];
            fourLaneEn_q <= cfgNv_q[`FSR_BIT_QUADD];
            regLockLive_q <= cfgNv_q[`FSR_BIT_SRPD];
         end else if (cfgNv_q[`FSR_BIT_SRPD]) begin
            regLockLive_q <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> dv/fsr_flag_bank_assertions.sv
// Port assertions for the flag bank
`timescale 1ns/1ps
`default_nettype none
module fsr_flag_bank_chk (
   input wire clk,
   input wire nrst,
   input wire csN,
   input wire misoOe_q,
   input wire opReq,
   input wire opIsChip,
   input wire opSectorProt,
   input wire opDone,
   input wire opFail,
   input wire opAccept_q,
   input wire busyFlag_q,
   input wire regLockLive_q,
   input wire [3:0] regionLock_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Op steps: failed finish, blocked request
   sequence failEnd;
      busyFlag_q && opDone && opFail;
   endsequence
   sequence blockedReq;
      opReq && opSectorProt && !opIsChip && !busyFlag_q;
   endsequence
   chk_fail_busy: assert property (
      failEnd |-> ##2 busyFlag_q [*3])
      else $error("busy dropped after failed op");
   chk_busy_refuse: assert property (
      opReq && busyFlag_q |=> !opAccept_q [*2])
      else $error("request accepted while busy");
   chk_blocked_req: assert property (
      blockedReq |=> !opAccept_q ##[0:2] busyFlag_q)
      else $error("blocked request not refused");
   chk_accept_busy: assert property (
      opAccept_q |-> ##[0:1] busyFlag_q)
      else $error("accepted op without busy");
   // Lock bits are one-time: a set bit never clears
   chk_lock_mono: assert property (
      (regionLock_q & $past(regionLock_q)) == $past(regionLock_q))
      else $error("region lock bit cleared");
   chk_oe_idle: assert property (
      csN [*5] |-> !misoOe_q)
      else $error("data out driven while deselected");
   chk_oe_rise: assert property (
      $rose(misoOe_q) |-> !csN)
      else $error("data out enabled outside frame");
   chk_reglock_stay: assert property (
      regLockLive_q |=> regLockLive_q)
      else $error("register lock released");
endmodule
`default_nettype wire

// >>> dv/fsr_host_model.sv
// SPI host model driving serial frames at the flag bank pins
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
   input wire clk,
   output logic csN,
   output logic sclk,
   output logic mosi,
   input wire miso_q
);
   // Idle: deselected, serial clock parked low
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // Mode 0 frame, MSB first, 400 ns serial period; rx keeps last byte
   task automatic frame(input logic [47:0] tx, input int nBytes,
      output logic [7:0] rx);
      repeat (2) @(negedge clk);
      csN = 1'b0;
      for (int i = 0; i < nBytes * 8; i++) begin
         mosi = tx[47 - i];
         repeat (4) @(negedge clk);
         rx = {rx[6:0], miso_q};
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      csN = 1'b1;
      mosi = ~mosi; // Released line keeps no stale value
      repeat (6) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the flag bank
`timescale 1ns/1ps
`default_nettype none
`include "fsr_consts.vh"
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic csN, sclk, mosi, miso_q, misoOe_q, acc, misoLine;
   logic opReq, opIsErase, opIsChip, opSecurity, opSectorProt, opDone;
   logic opFail, chipProtHit, eraseHalted, programHalted, cfgReload;
   logic opAccept_q, busyFlag_q, haltedOpIndicator_q, invertMapBit_q;
   logic fourLaneEn_q, regLockLive_q;
   logic [1:0] opRegion;
   logic [2:0] protectionModeField;
   logic [3:0] regionLock_q;
   logic [7:0] rx, cfg, nv;
   // Op kind {erase, chip, security, region, protected}, fail, hit
   logic [7:0] tbl [5] = '{8'h02, 8'h82, 8'h84, 8'h04, 8'hC5};
   int miscompares = 0;
   int cmp_count = 0;
   fsr_flag_bank i_dut (.clk, .nrst, .csN, .sclk, .mosi, .miso_q, .misoOe_q,
      .opReq, .opIsErase, .opIsChip, .opSecurity, .opRegion, .opSectorProt,
      .opDone, .opFail, .chipProtHit, .eraseHalted, .programHalted,
      .protectionModeField, .cfgReload, .opAccept_q, .busyFlag_q,
      .haltedOpIndicator_q, .invertMapBit_q, .fourLaneEn_q, .regLockLive_q,
      .regionLock_q);
   // Released data line floats to its pull-up, so a late enable shows
   assign misoLine = misoOe_q ? miso_q : 1'b1;
   fsr_host_model i_host (.clk, .csN, .sclk, .mosi, .miso_q(misoLine));
   // Status image after a failed or refused op of either kind
   function automatic logic [7:0] failStatus(input logic isErase);
      failStatus = isErase ? 8'h40 : 8'h20;
   endfunction
   // 20 MHz clock
   always #25 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      i_host.frame({c, 40'h0}, 1, rx);
   endtask
   // Status through both read paths must agree
   task automatic read_second_status_cmd(input logic [7:0] exp);
      i_host.frame({`FSR_CMD_RD_SR2, 40'h0}, 2, rx);
      check(rx, exp);
      i_host.frame({`FSR_CMD_RD_ANY, `FSR_ADDR_SR2, 16'h0}, 5, rx);
      check(rx, exp);
   endtask
   task automatic rdCfg(input logic [7:0] exp);
      i_host.frame({`FSR_CMD_RD_ANY, `FSR_ADDR_CONFIG_ONE_PERSISTENT, 16'h0}, 5, rx);
      check(rx, exp);
   endtask
   task automatic wrAny(input logic [23:0] a, input logic [7:0] v,
      input logic en);
      if (en) cmd(`FSR_CMD_WR_EN);
      i_host.frame({`FSR_CMD_WR_ANY, a, v, 8'h0}, 5, rx);
   endtask
   task automatic reload;
      cfgReload = 1'b1;
      @(negedge clk);
      cfgReload = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   // Request an op; if taken, finish it with the given outcome
   task automatic run(input logic [5:0] k, input logic fail, input logic hit);
      {opIsErase, opIsChip, opSecurity, opRegion, opSectorProt} = k;
      opReq = 1'b1;
      acc = 1'b0;
      // Accept pulse stands one cycle, first seen at the next fall
      repeat (3) begin
         @(negedge clk);
         opReq = 1'b0;
         acc = acc | opAccept_q;
      end
      if (acc) begin
         chipProtHit = hit;
         @(negedge clk);
         chipProtHit = 1'b0;
         opDone = 1'b1;
         opFail = fail;
         @(negedge clk);
         {opDone, opFail} = 2'h0;
      end
      repeat (3) @(negedge clk);
   endtask
   initial begin
      void'($urandom(66));
      {opReq, opIsErase, opIsChip, opSecurity, opRegion, opSectorProt} = '0;
      {opDone, opFail, chipProtHit, eraseHalted, programHalted} = '0;
      cfgReload = 1'b0;
      protectionModeField = 3'($urandom % 7);
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      read_second_status_cmd(8'h00);
      rdCfg(8'h00);
      // Suspend states show in the low bits; writes cannot touch them
      for (int i = 0; i < 4; i++) begin
         {eraseHalted, programHalted} = 2'(i);
         wrAny(`FSR_ADDR_SR2, 8'hFF, 1'b1);
         read_second_status_cmd(8'(i));
         check({7'h0, haltedOpIndicator_q}, {7'h0, i != 0});
      end
      {eraseHalted, programHalted} = 2'h0;
      // Failing or blocked ops latch a flag and hold busy until cleared
      for (int i = 0; i < 5; i++) begin
         run(tbl[i][7:2], tbl[i][1], tbl[i][0]);
         check({7'h0, acc}, {7'h0, !tbl[i][2] | tbl[i][6]});
         read_second_status_cmd(failStatus(tbl[i][7]));
         wrAny(`FSR_ADDR_SR2, 8'h00, 1'b1);
         run(6'h00, 1'b0, 1'b0);
         check({6'h0, busyFlag_q, acc}, 8'h02);
         read_second_status_cmd(failStatus(tbl[i][7]));
         cmd(`FSR_CMD_CLR);
         read_second_status_cmd(8'h00);
         check({7'h0, busyFlag_q}, 8'h00);
      end
      // Random config image through the two-byte register write
      cfg = 8'($urandom);
      nv = {1'b0, cfg[6:1], 1'b0};
      cmd(`FSR_CMD_WR_EN);
      i_host.frame({`FSR_CMD_WR_REGS, 8'h00, cfg, 24'h0}, 3, rx);
      rdCfg(nv);
      reload;
      check({1'b0, invertMapBit_q, regionLock_q, fourLaneEn_q,
         regLockLive_q}, nv);
      wrAny(`FSR_ADDR_CONFIG_ONE_PERSISTENT, nv ^ 8'h42, 1'b0);
      rdCfg(nv);
      // Lock region three; lock bits only accumulate
      cfg = {1'b0, ~nv[6], 4'h8, ~nv[1], 1'b1};
      nv = {1'b0, cfg[6], 1'b1, nv[4:2], cfg[1], 1'b0};
      wrAny(`FSR_ADDR_CONFIG_ONE_PERSISTENT, cfg, 1'b1);
      rdCfg(nv);
      reload;
      run(6'h0E, 1'b0, 1'b0);
      read_second_status_cmd(failStatus(1'b0));
      cmd(`FSR_CMD_CLR);
      // Register lock default programmable only in the open mode
      protectionModeField = `FSR_PROT_OTP_OPEN;
      nv[0] = 1'b1;
      wrAny(`FSR_ADDR_CONFIG_ONE_PERSISTENT, nv, 1'b1);
      rdCfg(nv);
      check({7'h0, regLockLive_q}, 8'h01);
      wrAny(`FSR_ADDR_CONFIG_ONE_PERSISTENT, nv ^ 8'h42, 1'b1);
      rdCfg(nv);
      wrap_up;
   end
endmodule
bind fsr_flag_bank fsr_flag_bank_chk i_chk (.clk, .nrst, .csN, .misoOe_q,
   .opReq, .opIsChip, .opSectorProt, .opDone, .opFail, .opAccept_q,
   .busyFlag_q, .regLockLive_q, .regionLock_q);
`default_nettype wire
